// [include/khmbx_pkg.sv]
// Purpose: Shared constants and types for the keyboard host mailbox
// Assumes: Host I/O addresses compared on the low byte only
// Notes: Status bit layout fixed; user bits 2 and 4-7 owned by the core
package khmbx_pkg;
   localparam logic [7:0] HOST_DATA_ADDR = 8'h60;
   localparam logic [7:0] HOST_CMD_ADDR = 8'h64;
   localparam int ST_OBF = 0;
   localparam int ST_IBF = 1;
   localparam int ST_CD = 3;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] USER_MASK = 8'hF4;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam int CLK_PERIOD_NS = 40;
   localparam int HOLD_NS = 500;
   localparam int HOLD_CLK_MIN = 6;
   localparam int HOLD_CYC_CALC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (HOLD_CYC_CALC > HOLD_CLK_MIN) ? HOLD_CYC_CALC
                                                          : HOLD_CLK_MIN;
   localparam int NPINS = 3;
   localparam logic [3:0] CNT_ZERO = 4'h0;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } khmbx_host_req_t;

   typedef struct packed {
      logic wr_out;
      logic rd_in;
      logic st_wr;
      logic [7:0] wdata;
   } khmbx_cpu_req_t;
endpackage : khmbx_pkg

// [hdl/khmbx_top.sv]
// Purpose: Host/core byte mailbox with status, IRQ gating and port pins
// Assumes: Host and core strobes are one-cycle pulses on CLK
// Notes: Port pins are split into output and output enable
// How it works
// - Host address 60 is data, 64 is command write and status read.
// - Host data write stores byte, clears command flag, sets input full.
// - Host command write stores byte, sets command flag, sets input full.
// - In flags mode host data read clears output full and keyboard irq.
// - Core write to output buffer sets output full, status bit 0.
// - Status bit 3 marks input byte as command (1) or data (0).
// - Flags mode: keyboard irq is output full gated by its port bit.
// - Keyboard irq is zero after reset.
// - Without flags mode keyboard irq follows its port bit.
// - Flags mode: mouse irq is inverted input full gated by port bit.
// - Without flags mode mouse irq follows its port bit.
// - Gate A20 output driven from a core-controlled port bit.
// - Push-pull mode: port one drives high briefly, releases after HOLD_CYCLES clocks (13 by default).
// - Open drain mode: one tristates, zero drives low.
// - Legacy pins are never inputs nor inverted in this mode.
// - Status cleared on reset, host read-only, core writes user bits.
// - Core read of input buffer clears input full flag.
// - Status: bit0 output full, bit1 input full, bit3 command flag.
`timescale 1ns/1ns
module khmbx_top
   import khmbx_pkg::*;
#(
   parameter int HOLD_CYCLES = HOLD_CYC
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic CE,
   input wire khmbx_pkg::khmbx_host_req_t HOST_REQ,
   output logic [7:0] HOST_RDATA,
   input wire khmbx_pkg::khmbx_cpu_req_t CPU_REQ,
   output logic [7:0] CPU_IN_DATA,
   output logic [7:0] CPU_STATUS,
   input wire logic FLAGS_EN,
   input wire logic KBD_IRQ_GATE_BIT,
   input wire logic MOUSE_IRQ_GATE_BIT,
   input wire logic GATE_A20_PORT_BIT,
   input wire logic [NPINS-1:0] LEGACY_PORT_VAL,
   input wire logic OPEN_DRAIN,
   output logic KEYBOARD_INTERRUPT_OUT,
   output logic MOUSE_INTERRUPT_OUT,
   output logic GATE_A20,
   output logic [NPINS-1:0] LEGACY_PIN_O,
   output logic [NPINS-1:0] LEGACY_PIN_OE
);
   import khmbx_pkg::*;

   // ---------------------------------------------------------------
   // Mailbox registers
   // ---------------------------------------------------------------
   logic [7:0] in_buf_q, in_buf_d;
   logic [7:0] out_buf_q, out_buf_d;
   logic [7:0] status_q, status_d;
   logic [7:0] rdata_q, rdata_d;
   logic host_dwr, host_cwr, host_drd, host_srd;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] m);
      hit = (a == m);
   endfunction : hit

   assign host_dwr = HOST_REQ.wr
      && hit(HOST_REQ.addr, HOST_DATA_ADDR);
   assign host_cwr = HOST_REQ.wr
      && hit(HOST_REQ.addr, HOST_CMD_ADDR);
   assign host_drd = HOST_REQ.rd
      && hit(HOST_REQ.addr, HOST_DATA_ADDR);
   assign host_srd = HOST_REQ.rd
      && hit(HOST_REQ.addr, HOST_CMD_ADDR);

   always_comb begin
      in_buf_d = in_buf_q;
      out_buf_d = out_buf_q;
      status_d = status_q;
      rdata_d = rdata_q;
      // User bits first so hardware flag updates below take priority
      if (CPU_REQ.st_wr) begin
         status_d = (status_q & ~USER_MASK)
            | (CPU_REQ.wdata & USER_MASK);
      end
      if (CPU_REQ.rd_in) begin
         status_d[ST_IBF] = 1'b0;
      end
      // Host read clears, core write sets: set wins in the same cycle
      if (host_drd && FLAGS_EN) begin
         status_d[ST_OBF] = 1'b0;
      end
      if (CPU_REQ.wr_out) begin
         out_buf_d = CPU_REQ.wdata;
         status_d[ST_OBF] = 1'b1;
      end
      if (host_dwr) begin
         in_buf_d = HOST_REQ.wdata;
         status_d[ST_CD] = 1'b0;
         status_d[ST_IBF] = 1'b1;
      end else if (host_cwr) begin
         in_buf_d = HOST_REQ.wdata;
         status_d[ST_CD] = 1'b1;
         status_d[ST_IBF] = 1'b1;
      end
      if (host_drd) begin
         rdata_d = out_buf_q;
      end else if (host_srd) begin
         rdata_d = status_q;
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         in_buf_q <= BYTE_RST;
         out_buf_q <= BYTE_RST;
         status_q <= STATUS_RST;
         rdata_q <= BYTE_RST;
      end else if (CE) begin
         in_buf_q <= in_buf_d;
         out_buf_q <= out_buf_d;
         status_q <= status_d;
         rdata_q <= rdata_d;
      end
   end

   assign HOST_RDATA = rdata_q;
   assign CPU_IN_DATA = in_buf_q;
   assign CPU_STATUS = status_q;

   // ---------------------------------------------------------------
   // Interrupt and gate outputs
   // ---------------------------------------------------------------
   logic keyboard_interrupt_out_q, keyboard_interrupt_out_d, mouse_interrupt_out_q, mouse_interrupt_out_d, a20_q, a20_d;

   always_comb begin
      if (FLAGS_EN) begin
         keyboard_interrupt_out_d = KBD_IRQ_GATE_BIT & status_d[ST_OBF];
         mouse_interrupt_out_d = MOUSE_IRQ_GATE_BIT & ~status_d[ST_IBF];
      end else begin
         keyboard_interrupt_out_d = KBD_IRQ_GATE_BIT;
         mouse_interrupt_out_d = MOUSE_IRQ_GATE_BIT;
      end
      a20_d = GATE_A20_PORT_BIT;
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         keyboard_interrupt_out_q <= 1'b0;
         mouse_interrupt_out_q <= 1'b0;
         a20_q <= 1'b0;
      end else if (CE) begin
         keyboard_interrupt_out_q <= keyboard_interrupt_out_d;
         mouse_interrupt_out_q <= mouse_interrupt_out_d;
         a20_q <= a20_d;
      end
   end

   assign KEYBOARD_INTERRUPT_OUT = keyboard_interrupt_out_q;
   assign MOUSE_INTERRUPT_OUT = mouse_interrupt_out_q;
   assign GATE_A20 = a20_q;

   // ---------------------------------------------------------------
   // Legacy port pins
   // ---------------------------------------------------------------
   // Pins are output only here; no input or invert path exists at all
   logic [NPINS-1:0] pin_o_q, pin_o_d, pin_oe_q, pin_oe_d, val_q;
   logic [3:0] cnt_q [NPINS];
   logic [3:0] cnt_d [NPINS];
   localparam logic [3:0] HOLD_LD = 4'(HOLD_CYCLES);

   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         cnt_d[i] = cnt_q[i];
         pin_o_d[i] = 1'b0;
         pin_oe_d[i] = 1'b1;
         if (!LEGACY_PORT_VAL[i]) begin
            cnt_d[i] = CNT_ZERO;
            pin_oe_d[i] = 1'b1;
         end else if (OPEN_DRAIN) begin
            cnt_d[i] = CNT_ZERO;
            pin_oe_d[i] = 1'b0;
         end else begin
            // Low-to-high edge starts the active pull-up window
            if (!val_q[i]) begin
               cnt_d[i] = HOLD_LD;
            end else if (cnt_q[i] != CNT_ZERO) begin
               cnt_d[i] = cnt_q[i] - 4'h1;
            end
            pin_o_d[i] = 1'b1;
            pin_oe_d[i] = (cnt_d[i] != CNT_ZERO);
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!NRST) begin
         pin_o_q <= '0;
         pin_oe_q <= '1;
         val_q <= '0;
         for (int i = 0; i < NPINS; i++) begin
            cnt_q[i] <= CNT_ZERO;
         end
      end else if (CE) begin
         pin_o_q <= pin_o_d;
         pin_oe_q <= pin_oe_d;
         val_q <= LEGACY_PORT_VAL;
         for (int i = 0; i < NPINS; i++) begin
            cnt_q[i] <= cnt_d[i];
         end
      end
   end

   assign LEGACY_PIN_O = pin_o_q;
   assign LEGACY_PIN_OE = pin_oe_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_data_wr;
      @(posedge CLK) disable iff (!NRST)
      (CE && host_dwr) |=> (status_q[ST_IBF] && !status_q[ST_CD]);
   endproperty
   a_data_wr: assert property (p_data_wr)
      else $error("data write flags");

   property p_cmd_wr;
      @(posedge CLK) disable iff (!NRST)
      (CE && host_cwr && !host_dwr) |=> (status_q[ST_IBF] && status_q[ST_CD]);
   endproperty
   a_cmd_wr: assert property (p_cmd_wr)
      else $error("cmd write flags");

   property p_obf_set;
      @(posedge CLK) disable iff (!NRST)
      (CE && CPU_REQ.wr_out)
         |=> (status_q[ST_OBF] && out_buf_q == $past(CPU_REQ.wdata));
   endproperty
   a_obf_set: assert property (p_obf_set)
      else $error("obf not set");

   property p_obf_clr;
      @(posedge CLK) disable iff (!NRST)
      (CE && FLAGS_EN && host_drd && !CPU_REQ.wr_out) |=> !status_q[ST_OBF];
   endproperty
   a_obf_clr: assert property (p_obf_clr)
      else $error("obf not cleared");

   property p_ibf_clr;
      @(posedge CLK) disable iff (!NRST)
      (CE && CPU_REQ.rd_in && !host_dwr && !host_cwr) |=> !status_q[ST_IBF];
   endproperty
   a_ibf_clr: assert property (p_ibf_clr)
      else $error("ibf not cleared");

   property p_keyboard_interrupt_out;
      @(posedge CLK) disable iff (!NRST)
      (CE && FLAGS_EN)
         |=> (keyboard_interrupt_out_q == ($past(KBD_IRQ_GATE_BIT) && status_q[ST_OBF]));
   endproperty
   a_keyboard_interrupt_out: assert property (p_keyboard_interrupt_out)
      else $error("keyboard_interrupt_out gating");

   property p_mouse_interrupt_out;
      @(posedge CLK) disable iff (!NRST)
      (CE && FLAGS_EN)
         |=> (mouse_interrupt_out_q == ($past(MOUSE_IRQ_GATE_BIT) && !status_q[ST_IBF]));
   endproperty
   a_mouse_interrupt_out: assert property (p_mouse_interrupt_out)
      else $error("mouse_interrupt_out gating");

   property p_keyboard_interrupt_out_direct;
      @(posedge CLK) disable iff (!NRST)
      (CE && !FLAGS_EN) |=> (keyboard_interrupt_out_q == $past(KBD_IRQ_GATE_BIT));
   endproperty
   a_keyboard_interrupt_out_direct: assert property (p_keyboard_interrupt_out_direct)
      else $error("keyboard_interrupt_out direct");

   property p_od;
      @(posedge CLK) disable iff (!NRST)
      (CE && OPEN_DRAIN && LEGACY_PORT_VAL[0]) |=> !LEGACY_PIN_OE[0];
   endproperty
   a_od: assert property (p_od)
      else $error("open drain drives");

   property p_low;
      @(posedge CLK) disable iff (!NRST)
      (CE && !LEGACY_PORT_VAL[0]) |=> (LEGACY_PIN_OE[0] && !LEGACY_PIN_O[0]);
   endproperty
   a_low: assert property (p_low)
      else $error("pin not low");

   property p_mouse_interrupt_out_direct;
      @(posedge CLK) disable iff (!NRST)
      (CE && !FLAGS_EN) |=> (mouse_interrupt_out_q == $past(MOUSE_IRQ_GATE_BIT));
   endproperty
   a_mouse_interrupt_out_direct: assert property (p_mouse_interrupt_out_direct)
      else $error("mouse_interrupt_out direct");

   property p_a20;
      @(posedge CLK) disable iff (!NRST)
      CE |=> (a20_q == $past(GATE_A20_PORT_BIT));
   endproperty
   a_a20: assert property (p_a20)
      else $error("gate a20 follow");

   property p_keyboard_interrupt_out_rst;
      @(posedge CLK)
      !NRST |=> !keyboard_interrupt_out_q;
   endproperty
   a_keyboard_interrupt_out_rst: assert property (p_keyboard_interrupt_out_rst)
      else $error("keyboard_interrupt_out after reset");

   property p_status_rst;
      @(posedge CLK)
      !NRST |=> (status_q == STATUS_RST);
   endproperty
   a_status_rst: assert property (p_status_rst)
      else $error("status after reset");

   property p_status_rd;
      @(posedge CLK) disable iff (!NRST)
      (CE && host_srd) |=> (HOST_RDATA == $past(status_q));
   endproperty
   a_status_rd: assert property (p_status_rd)
      else $error("status read data");

   property p_pp_hold;
      @(posedge CLK) disable iff (!NRST)
      (CE && !OPEN_DRAIN && LEGACY_PORT_VAL[0] && !val_q[0])
         |=> (LEGACY_PIN_OE[0] && LEGACY_PIN_O[0]);
   endproperty
   a_pp_hold: assert property (p_pp_hold)
      else $error("push pull not driving high");
endmodule : khmbx_top

// [tb/khmbx_host_model.sv]
// Purpose: Host side model issuing I/O reads and writes to the mailbox
// Assumes: One request pulse per transfer, answer sampled after it
// Notes: Released address and data show the inverse of the last value
`timescale 1ns/1ns
module khmbx_host_model (
   input wire logic clk,
   input wire logic [7:0] rdata,
   output khmbx_pkg::khmbx_host_req_t req
);
   import khmbx_pkg::*;
   logic [7:0] rd_q;
   int gap, poll_miss;
   initial begin
      req = '0;
      gap = 0;
      poll_miss = 0;
   end
   // Gap lets the host answer slowly as well as promptly
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      #1 rd_q = rdata;
   endtask : xfer
   // Poll first; after 20 more busy polls the byte is written anyway
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      xfer(1'b0, HOST_CMD_ADDR, 8'h00);
      while (rd_q[ST_IBF] !== 1'b0 && n < 20) begin
         xfer(1'b0, HOST_CMD_ADDR, 8'h00);
         n++;
      end
      if (n >= 20) poll_miss++;
      xfer(1'b1, a, d);
   endtask : put
endmodule : khmbx_host_model

// [tb/keyboard_host_mailbox_tb.sv]
// Purpose: Self-checking bench for the keyboard host mailbox
// Assumes: Hold count shortened to six clocks
// Notes: Integer model predicts flags, irqs, data and pins
`timescale 1ns/1ns
module keyboard_host_mailbox_tb;
   import khmbx_pkg::*;
   localparam int HOLD = 6;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   khmbx_host_req_t hreq;
   khmbx_cpu_req_t cpu = '0;
   logic [7:0] hrd, cin, cst, b;
   logic flags = 1'b0, kg = 1'b0, mg = 1'b0, a20b = 1'b0, od = 1'b0;
   logic ce = 1'b1;
   logic [2:0] pval = 3'h0;
   logic keyboard_interrupt_out, mouse_interrupt_out, ga20;
   logic [2:0] po, poe;
   int err_total = 0, checked = 0, n;
   int m_obf = 0, m_ibf = 0, m_cd = 0, m_in = 0, m_out = 0, m_usr = 0;
   logic [31:0] seed = 32'hB351;
   always #20 clk = ~clk;
   khmbx_host_model host (.clk(clk), .rdata(hrd), .req(hreq));
   khmbx_top #(.HOLD_CYCLES(HOLD)) dut (.CLK(clk), .NRST(nrst),
      .CE(ce), .HOST_REQ(hreq), .HOST_RDATA(hrd), .CPU_REQ(cpu),
      .CPU_IN_DATA(cin), .CPU_STATUS(cst), .FLAGS_EN(flags),
      .KBD_IRQ_GATE_BIT(kg), .MOUSE_IRQ_GATE_BIT(mg),
      .GATE_A20_PORT_BIT(a20b), .LEGACY_PORT_VAL(pval),
      .OPEN_DRAIN(od), .KEYBOARD_INTERRUPT_OUT(keyboard_interrupt_out),
      .MOUSE_INTERRUPT_OUT(mouse_interrupt_out), .GATE_A20(ga20),
      .LEGACY_PIN_O(po), .LEGACY_PIN_OE(poe));
   // ------------------------------------------------------------
   // Compare and model tasks
   // ------------------------------------------------------------
   task automatic chk8(input string s, input logic [7:0] e,
                       input logic [7:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask : chk8
   task automatic chk1(input string s, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s exp %b got %b", s, e, g);
      end
   endtask : chk1
   function automatic logic [7:0] st_e();
      return 8'((m_usr & 8'hF4) | (m_cd << 3) | (m_ibf << 1) | m_obf);
   endfunction : st_e
   task automatic chk_all();
      chk8("status", st_e(), cst);
      chk1("keyboard_interrupt_out", flags ? (kg & m_obf[0]) : kg, keyboard_interrupt_out);
      chk1("mouse_interrupt_out", flags ? (mg & !m_ibf[0]) : mg, mouse_interrupt_out);
   endtask : chk_all
   task automatic cpu_op(input logic wo, ri, sw, input logic [7:0] d);
      @(posedge clk);
      cpu <= '{wr_out: wo, rd_in: ri, st_wr: sw, wdata: d};
      @(posedge clk);
      cpu <= '0;
      #1;
   endtask : cpu_op
   task automatic nxt();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      b = seed[7:0];
   endtask : nxt
   task automatic close_out();
      $display("counts checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   initial begin
      repeat (6000) @(posedge clk);
      err_total++;
      close_out();
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      #1;
      chk_all();
      chk8("pin_oe", 8'h07, 8'(poe));
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         {flags, kg, mg} <= i[2:0];
         @(posedge clk);
         #1;
         chk_all();
         nxt();
         host.gap = int'(b[1:0]);
         host.put(i[0] ? HOST_CMD_ADDR : HOST_DATA_ADDR, b);
         m_in = b; m_ibf = 1; m_cd = i[0];
         chk8("in_data", m_in[7:0], cin);
         chk_all();
         cpu_op(1'b0, 1'b1, 1'b0, 8'h00);
         m_ibf = 0;
         chk_all();
         nxt();
         cpu_op(1'b1, 1'b0, 1'b0, b);
         m_out = b; m_obf = 1;
         chk_all();
         host.xfer(1'b0, HOST_DATA_ADDR, 8'h00);
         if (flags) m_obf = 0;
         chk8("rdata", m_out[7:0], host.rd_q);
         chk_all();
      end
      $display("test mailbox done");
      cpu_op(1'b0, 1'b0, 1'b1, 8'hFF);
      m_usr = 8'hFF;
      host.xfer(1'b1, 8'h61, 8'h5A);
      host.xfer(1'b0, HOST_CMD_ADDR, 8'h00);
      chk8("host_st", st_e(), host.rd_q);
      chk8("in_keep", m_in[7:0], cin);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         a20b <= !i[0];
         @(posedge clk);
         #1;
         chk1("a20", !i[0], ga20);
      end
      $display("test status a20 done");
      for (int m = 0; m < 2; m++) begin
         @(posedge clk);
         od <= m[0];
         pval <= 3'h7;
         @(posedge clk);
         #1;
         chk8("pin_o", m[0] ? 8'h00 : 8'h07, 8'(po));
         n = 0;
         while (poe === 3'h7 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
         end
         chk8("hold", m[0] ? 8'h00 : 8'(HOLD), 8'(n));
         chk8("pin_rel", 8'h00, 8'(poe));
         @(posedge clk);
         pval <= 3'h0;
         @(posedge clk);
         #1;
         chk8("pin_lo_o", 8'h00, 8'(po));
         chk8("pin_lo_oe", 8'h07, 8'(poe));
      end
      $display("test pins done");
      // Frozen core write must leave flags and output buffer alone
      @(posedge clk);
      ce <= 1'b0;
      cpu_op(1'b1, 1'b0, 1'b0, 8'h3C);
      chk_all();
      @(posedge clk);
      ce <= 1'b1;
      host.xfer(1'b0, HOST_DATA_ADDR, 8'h00);
      chk8("frozen_out", m_out[7:0], host.rd_q);
      @(posedge clk);
      flags <= 1'b0;
      @(posedge clk);
      #1;
      chk1("keyboard_interrupt_out_pre", 1'b1, keyboard_interrupt_out);
      @(posedge clk);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      #1;
      chk1("keyboard_interrupt_out_rst", 1'b0, keyboard_interrupt_out);
      chk8("st_rst", STATUS_RST, cst);
      m_obf = 0; m_ibf = 0; m_cd = 0; m_usr = 0;
      chk8("poll_miss", 8'h00, 8'(host.poll_miss));
      $display("test freeze reset done");
      close_out();
   end
endmodule : keyboard_host_mailbox_tb
